// [shared/serial_port_pkg.sv]
// Constants and types shared by the asynchronous serial port.
`default_nettype none
package serial_port_pkg;
  // ==========================================================
  // Register addresses on the CPU memory port.
  localparam int          ADDR_W     = 16;
  localparam logic [15:0] ADDR_MODE  = 16'hff70;
  localparam logic [15:0] ADDR_RATE  = 16'hff71;
  localparam logic [15:0] ADDR_DATA  = 16'hff72;
  localparam logic [15:0] ADDR_ERR   = 16'hff73;
  // ==========================================================
  // Reset values.
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] RATE_RESET = 8'h1f;
  localparam logic [7:0] RXB_RESET  = 8'hff;
  localparam logic [7:0] TXS_RESET  = 8'hff;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  // ==========================================================
  // Field positions of the operation mode register.
  localparam int BIT_POWER = 7;
  localparam int BIT_TXE   = 6;
  localparam int BIT_RXE   = 5;
  localparam int BIT_PS_HI = 4;
  localparam int BIT_PS_LO = 3;
  localparam int BIT_CL    = 2;
  localparam int BIT_SL    = 1;
  // Field positions of the error status register.
  localparam int BIT_PE    = 2;
  localparam int BIT_FE    = 1;
  localparam int BIT_OVE   = 0;
  // Field positions of the bit rate control register.
  localparam int BIT_SRC_HI = 7;
  localparam int BIT_SRC_LO = 6;
  localparam int DIV_HI     = 4;
  localparam int DIV_W      = 5;
  localparam int CNT_W      = 6;
  localparam int PRE_W      = 5;
  // ==========================================================
  // Parity modes.
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_ODD  = 2'b10,
    PAR_EVEN = 2'b11
  } parity_type;
  // Base clock sources.
  typedef enum logic [1:0] {
    SRC_TIMER = 2'b00,
    SRC_DIV2  = 2'b01,
    SRC_DIV8  = 2'b10,
    SRC_DIV32 = 2'b11
  } source_type;
  // Frame states, common to both directions.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } frame_state_type;
  // Index of the last data bit for each length.
  localparam logic [2:0] LAST_BIT7 = 3'h6;
  localparam logic [2:0] LAST_BIT8 = 3'h7;
endpackage
`default_nettype wire

// [rtl/enable_sync.sv]
// Two-stage synchroniser of an enable bit onto the base clock tick.
`default_nettype none
module enable_sync
  import serial_port_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic clr,
  input  wire logic tick,
  input  wire logic en_in,
  output logic      en_out
);
  logic stage1_q;
  logic en_q;

  // Both stages advance only on the base clock tick.
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      stage1_q <= 1'b0;
      en_q     <= 1'b0;
    end else if (tick) begin
      stage1_q <= en_in;
      en_q     <= stage1_q;
    end
  end

  assign en_out = en_q;
endmodule
`default_nettype wire

// [rtl/serial_tx.sv]
// Transmit framer: start bit, data LSB first, parity, stop bits.
`default_nettype none
module serial_tx
  import serial_port_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             clr,
  input  wire logic             tick,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic [1:0]       parity,
  input  wire logic             len8,
  input  wire logic             two_stop,
  input  wire logic             start,
  input  wire logic [7:0]       data,
  output logic                  serial_out,
  output logic                  done
);
  frame_state_type  state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [2:0]       idx_q;
  logic [7:0]       shift_q;
  logic             par_q;
  logic             stop2_q;
  logic             out_q;
  logic             done_q;

  wire [CNT_W-1:0] bit_len  = {divisor, 1'b0};
  wire             bit_end  = tick && (cnt_q == bit_len - CNT_W'(1));
  wire [2:0]       last_idx = len8 ? LAST_BIT8 : LAST_BIT7;
  wire [7:0]       data_m   = len8 ? data : {1'b0, data[6:0]};
  wire             par_gen  = (parity == PAR_ODD)  ? ~^data_m :
                              (parity == PAR_EVEN) ? ^data_m : 1'b0;

  always_ff @(posedge ref_clk) begin
    done_q <= 1'b0;
    if (clr) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      idx_q   <= '0;
      shift_q <= TXS_RESET;
      par_q   <= 1'b0;
      stop2_q <= 1'b0;
      out_q   <= 1'b1;
    end else begin
      if (tick)
        cnt_q <= bit_end ? '0 : cnt_q + CNT_W'(1);
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_START;
            cnt_q   <= '0;
            idx_q   <= '0;
            shift_q <= data_m;
            par_q   <= par_gen;
            stop2_q <= two_stop;
            out_q   <= 1'b0;
          end
        end
        ST_START: begin
          if (bit_end) begin
            state_q <= ST_DATA;
            out_q   <= shift_q[0];
          end
        end
        ST_DATA: begin
          if (bit_end) begin
            shift_q <= {1'b1, shift_q[7:1]};
            idx_q   <= idx_q + 3'h1;
            if (idx_q == last_idx) begin
              state_q <= (parity == PAR_NONE) ? ST_STOP : ST_PAR;
              out_q   <= (parity == PAR_NONE) ? 1'b1 : par_q;
            end else begin
              out_q   <= shift_q[1];
            end
          end
        end
        ST_PAR: begin
          if (bit_end) begin
            state_q <= ST_STOP;
            out_q   <= 1'b1;
          end
        end
        ST_STOP: begin
          if (bit_end) begin
            if (stop2_q) begin
              stop2_q <= 1'b0;
            end else begin
              state_q <= ST_IDLE;
              done_q  <= 1'b1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign serial_out = out_q;
  assign done       = done_q;
endmodule
`default_nettype wire

// [rtl/async_serial_port.sv]
// Asynchronous serial port: CPU registers, base clock, receiver.
`default_nettype none
module async_serial_port
  import serial_port_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] cpu_addr,
  input  wire logic              cpu_wr,
  input  wire logic              cpu_rd,
  input  wire logic [7:0]        cpu_wdata,
  output logic      [7:0]        cpu_rdata,
  input  wire logic              timer_tick,
  input  wire logic              serial_in_pin,
  output logic                   serial_out_pin,
  output logic                   transmit_done_interrupt,
  output logic                   receive_done_interrupt,
  output logic                   receive_error_interrupt
);
  // ==========================================================
  // Registers and state.
  logic [7:0]       mode_q;
  logic [7:0]       rate_q;
  logic [7:0]       rxb_q;
  logic [7:0]       txs_q;
  logic             tx_start_q;
  logic             buf_full_q;
  logic             pe_q;
  logic             fe_q;
  logic             ove_q;
  logic [7:0]       rdata_q;
  logic [PRE_W-1:0] pre_q;
  frame_state_type  rx_state_q;
  logic [CNT_W-1:0] rx_cnt_q;
  logic [2:0]       rx_idx_q;
  logic [7:0]       rx_shift_q;
  logic             rx_par_q;
  logic             rx_done_q;
  logic             rx_err_q;

  // ==========================================================
  // Mode and rate fields.
  wire             power     = mode_q[BIT_POWER];
  wire             txe_bit   = mode_q[BIT_TXE];
  wire             rxe_bit   = mode_q[BIT_RXE];
  wire [1:0]       parity    = mode_q[BIT_PS_HI:BIT_PS_LO];
  wire             len8      = mode_q[BIT_CL];
  wire             two_stop  = mode_q[BIT_SL];
  wire [1:0]       source    = rate_q[BIT_SRC_HI:BIT_SRC_LO];
  wire [DIV_W-1:0] divisor   = rate_q[DIV_HI:0];

  wire blk_clr = !nrst || !power;

  // ==========================================================
  // Address decoding for the CPU memory port.
  wire sel_mode = (cpu_addr == ADDR_MODE);
  wire sel_rate = (cpu_addr == ADDR_RATE);
  wire sel_data = (cpu_addr == ADDR_DATA);
  wire sel_err  = (cpu_addr == ADDR_ERR);
  wire wr_mode  = cpu_wr && sel_mode;
  wire wr_rate  = cpu_wr && sel_rate;
  wire wr_txs   = cpu_wr && sel_data;
  wire rd_rxb   = cpu_rd && sel_data;
  wire rd_err   = cpu_rd && sel_err;
  wire [7:0] err_view = {5'h00, pe_q, fe_q, ove_q};

  // Read data selection; the transmit register is write-only.
  wire [7:0] rd_sel = sel_mode ? mode_q :
                      sel_rate ? rate_q :
                      sel_data ? rxb_q :
                      sel_err  ? err_view : ZERO_BYTE;

  // Mode and rate registers follow only the system reset.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_q <= MODE_RESET;
      rate_q <= RATE_RESET;
    end else begin
      if (wr_mode)
        mode_q <= cpu_wdata;
      if (wr_rate)
        rate_q <= cpu_wdata;
    end
  end

  // Read data register, captured on a read strobe.
  always_ff @(posedge ref_clk) begin
    if (!nrst)
      rdata_q <= ZERO_BYTE;
    else if (cpu_rd)
      rdata_q <= rd_sel;
  end

  // ==========================================================
  // Base clock: prescaler and source selection.
  // The prescaler stands still while the block is off.
  always_ff @(posedge ref_clk) begin
    if (blk_clr)
      pre_q <= '0;
    else
      pre_q <= pre_q + PRE_W'(1);
  end

  wire base_tick = power && (
    (source == SRC_TIMER) ? timer_tick :
    (source == SRC_DIV2)  ? (pre_q[0] == 1'b1) :
    (source == SRC_DIV8)  ? (pre_q[2:0] == 3'h7) :
                            (pre_q == 5'h1f));

  // ==========================================================
  // Enable bits synchronised to the base clock.
  logic tx_en;
  logic rx_en;

  enable_sync tx_sync (
    .ref_clk (ref_clk),
    .clr     (blk_clr),
    .tick    (base_tick),
    .en_in   (txe_bit),
    .en_out  (tx_en)
  );

  enable_sync rx_sync (
    .ref_clk (ref_clk),
    .clr     (blk_clr),
    .tick    (base_tick),
    .en_in   (rxe_bit),
    .en_out  (rx_en)
  );

  // ==========================================================
  // Transmit register and transmitter.
  // all ones when disabled
  always_ff @(posedge ref_clk) begin
    if (blk_clr || !txe_bit) begin
      txs_q      <= TXS_RESET;
      tx_start_q <= 1'b0;
    end else begin
      tx_start_q <= wr_txs && tx_en;
      if (wr_txs)
        txs_q <= cpu_wdata;
    end
  end

  wire tx_clr = blk_clr || !tx_en;

  serial_tx tx_unit (
    .ref_clk    (ref_clk),
    .clr        (tx_clr),
    .tick       (base_tick),
    .divisor    (divisor),
    .parity     (parity),
    .len8       (len8),
    .two_stop   (two_stop),
    .start      (tx_start_q),
    .data       (txs_q),
    .serial_out (serial_out_pin),
    .done       (transmit_done_interrupt)
  );

  // ==========================================================
  // Receiver timing.
  // input high while off
  wire rxd = power ? serial_in_pin : 1'b1;

  wire [CNT_W-1:0] bit_len  = {divisor, 1'b0};
  wire [CNT_W-1:0] half_len = {1'b0, divisor};
  wire             rx_half  = base_tick && (rx_cnt_q == half_len - CNT_W'(1));
  wire             rx_bit   = base_tick && (rx_cnt_q == bit_len - CNT_W'(1));
  wire [2:0]       rx_last  = len8 ? LAST_BIT8 : LAST_BIT7;

  wire [7:0] rx_data = len8 ? rx_shift_q : {1'b0, rx_shift_q[7:1]};

  wire par_bad = (parity == PAR_ODD)  ? ~(^rx_data ^ rx_par_q) :
                 (parity == PAR_EVEN) ? (^rx_data ^ rx_par_q) : 1'b0;

  // Character completes at the middle of the first stop bit.
  wire rx_end = (rx_state_q == ST_STOP) && rx_bit;
  wire stop_bad = !rxd;

  wire rx_clr = blk_clr || !rx_en;

  // ==========================================================
  // Receiver frame sequencer.
  always_ff @(posedge ref_clk) begin
    if (rx_clr) begin
      rx_state_q <= ST_IDLE;
      rx_cnt_q   <= '0;
      rx_idx_q   <= '0;
      rx_shift_q <= ZERO_BYTE;
      rx_par_q   <= 1'b0;
    end else begin
      if (base_tick)
        rx_cnt_q <= rx_bit ? '0 : rx_cnt_q + CNT_W'(1);
      case (rx_state_q)
        ST_IDLE: begin
          if (!rxd) begin
            rx_state_q <= ST_START;
            rx_cnt_q   <= '0;
          end
        end
        ST_START: begin
          // A start bit still low at its middle is genuine.
          if (rx_half) begin
            rx_cnt_q   <= '0;
            rx_idx_q   <= '0;
            rx_state_q <= rxd ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_bit) begin
            rx_shift_q <= {rxd, rx_shift_q[7:1]};
            rx_idx_q   <= rx_idx_q + 3'h1;
            if (rx_idx_q == rx_last)
              rx_state_q <= (parity == PAR_NONE) ? ST_STOP : ST_PAR;
          end
        end
        ST_PAR: begin
          if (rx_bit) begin
            rx_par_q   <= rxd;
            rx_state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rx_bit)
            rx_state_q <= ST_IDLE;
        end
        default: rx_state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Receive buffer and its full flag.
  always_ff @(posedge ref_clk) begin
    if (blk_clr) begin
      rxb_q      <= RXB_RESET;
      buf_full_q <= 1'b0;
    end else begin
      if (rx_end && !buf_full_q) begin
        rxb_q      <= rx_data;
        buf_full_q <= 1'b1;
      end else if (rd_rxb) begin
        buf_full_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Error flags: a new error wins over a clearing read.
  wire set_pe  = rx_end && par_bad;
  wire set_fe  = rx_end && stop_bad;
  wire set_ove = rx_end && buf_full_q;

  always_ff @(posedge ref_clk) begin
    if (blk_clr || (!power && !rxe_bit)) begin
      pe_q  <= 1'b0;
      fe_q  <= 1'b0;
      ove_q <= 1'b0;
    end else begin
      pe_q  <= set_pe  || (pe_q  && !rd_err);
      fe_q  <= set_fe  || (fe_q  && !rd_err);
      ove_q <= set_ove || (ove_q && !rd_err);
    end
  end

  // Completion and error pulses toward the interrupt controller.
  always_ff @(posedge ref_clk) begin
    if (rx_clr) begin
      rx_done_q <= 1'b0;
      rx_err_q  <= 1'b0;
    end else begin
      rx_done_q <= rx_end && !buf_full_q;
      rx_err_q  <= set_pe || set_fe || set_ove;
    end
  end

  // ==========================================================
  // Outputs.
  assign cpu_rdata               = rdata_q;
  assign receive_done_interrupt  = rx_done_q;
  assign receive_error_interrupt = rx_err_q;
endmodule
`default_nettype wire

// [bench/async_serial_port_asserts.sv]
// Port-level checks of the serial port, bound to its top module.
`default_nettype none
module async_serial_port_asserts
  import serial_port_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic              cpu_wr,
  input wire logic              cpu_rd,
  input wire logic [7:0]        cpu_wdata,
  input wire logic [7:0]        cpu_rdata,
  input wire logic              timer_tick,
  input wire logic              serial_in_pin,
  input wire logic              serial_out_pin,
  input wire logic              transmit_done_interrupt,
  input wire logic              receive_done_interrupt,
  input wire logic              receive_error_interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mode_q;
  logic       rx7_q;
  // Register strobes decoded from the CPU port.
  wire rd_data = cpu_rd && cpu_addr == ADDR_DATA;
  wire rd_err  = cpu_rd && cpu_addr == ADDR_ERR;
  wire wr_mode = cpu_wr && cpu_addr == ADDR_MODE;
  wire on_now  = mode_q[BIT_POWER];
  // Mode shadow and length of the last stored character.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_q <= MODE_RESET;
      rx7_q  <= 1'h0;
    end else begin
      if (wr_mode) begin
        mode_q <= cpu_wdata;
      end
      if (!on_now) begin
        rx7_q <= 1'h0;
      end else if (receive_done_interrupt) begin
        rx7_q <= !mode_q[BIT_CL];
      end
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  property p_mode_back;
    cpu_rd && cpu_addr == ADDR_MODE |=> cpu_rdata == mode_q;
  endproperty
  a_mode_back: assert property (p_mode_back) else $error("mode register reads back wrong");
  property p_off_buf;
    rd_data && !on_now && !$past(on_now) |=> cpu_rdata == RXB_RESET;
  endproperty
  a_off_buf: assert property (p_off_buf) else $error("buffer not all ones while off");
  property p_rx7;
    rd_data && rx7_q |=> !cpu_rdata[7];
  endproperty
  a_rx7: assert property (p_rx7) else $error("seven-bit character has top bit set");
  property p_err_reread;
    rd_err ##2 rd_err |=> cpu_rdata == ZERO_BYTE;
  endproperty
  a_err_reread: assert property (p_err_reread) else $error("error flags survive a read");
  property p_zero_par;
    rd_err && mode_q[BIT_PS_HI:BIT_PS_LO] == PAR_ZERO |=> !cpu_rdata[BIT_PE];
  endproperty
  a_zero_par: assert property (p_zero_par) else $error("parity flagged in zero mode");
  property p_tx_start;
    cpu_wr && cpu_addr == ADDR_DATA && on_now && mode_q[BIT_TXE] |-> ##[1:4] !serial_out_pin;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit after data write");
  property p_done;
    transmit_done_interrupt |-> serial_out_pin ##1 !transmit_done_interrupt;
  endproperty
  a_done: assert property (p_done) else $error("done pulse malformed");
  property p_off_idle;
    wr_mode && !cpu_wdata[BIT_TXE] |-> ##12 serial_out_pin [*4];
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("line not idle after disable");
  property p_off_quiet;
    !on_now && !$past(on_now) |-> !receive_done_interrupt && !receive_error_interrupt;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("receive event while off");
endmodule
bind async_serial_port async_serial_port_asserts chk_u (
  .ref_clk(ref_clk), .nrst(nrst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
  .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .timer_tick(timer_tick),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .transmit_done_interrupt(transmit_done_interrupt), .receive_done_interrupt(receive_done_interrupt),
  .receive_error_interrupt(receive_error_interrupt)
);
`default_nettype wire

// [bench/remote_serial_peer.sv]
// Behavioural remote serial transceiver on the two data lines.
`default_nettype none
module remote_serial_peer
  import serial_port_pkg::*;
#(
  parameter int BIT_CLKS = 32
)
(
  input  wire logic       ref_clk,
  input  wire logic       line_in,
  output var  logic       line_out,
  input  wire logic [1:0] parity,
  input  wire logic       len8,
  input  wire logic       two_stop,
  output var  logic       got_valid,
  output var  logic [8:0] got_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx_d;
  logic       rx_ok;
  // Parity bit for the current mode.
  // parity per mode
  function automatic logic par_bit(input logic [7:0] d);
    return (parity == PAR_ODD) ? ~^d : (parity == PAR_EVEN) ? ^d : 1'h0;
  endfunction
  // Sends one frame; flip inverts the parity bit.
  // start, data LSB first, parity, one stop
  task automatic send_frame(input logic [7:0] d, input logic flip);
    @(negedge ref_clk);
    line_out = 1'h0;
    repeat (BIT_CLKS) @(negedge ref_clk);
    for (int i = 0; i < (len8 ? 8 : 7); i++) begin
      line_out = d[i];
      repeat (BIT_CLKS) @(negedge ref_clk);
    end
    if (parity != PAR_NONE) begin
      line_out = par_bit(len8 ? d : {1'h0, d[6:0]}) ^ flip;
      repeat (BIT_CLKS) @(negedge ref_clk);
    end
    line_out = 1'h1;
    repeat (BIT_CLKS) @(negedge ref_clk);
  endtask
  // Decodes frames from the port, sampling mid-bit.
  // frame layout on the line
  initial begin
    line_out = 1'h1;
    got_valid = 1'h0;
    got_word = '0;
    forever begin
      @(negedge line_in);
      repeat (BIT_CLKS / 2) @(posedge ref_clk);
      rx_ok = !line_in;
      rx_d = '0;
      for (int i = 0; i < (len8 ? 8 : 7); i++) begin
        repeat (BIT_CLKS) @(posedge ref_clk);
        rx_d[i] = line_in;
      end
      if (parity != PAR_NONE) begin
        repeat (BIT_CLKS) @(posedge ref_clk);
        rx_ok = rx_ok && (line_in == par_bit(rx_d));
      end
      repeat (BIT_CLKS) @(posedge ref_clk);
      rx_ok = rx_ok && line_in;
      if (two_stop) begin
        repeat (BIT_CLKS) @(posedge ref_clk);
        rx_ok = rx_ok && line_in;
      end
      got_word <= {rx_ok, rx_d};
      got_valid <= 1'h1;
      @(posedge ref_clk);
      got_valid <= 1'h0;
    end
  end
endmodule
`default_nettype wire

// [bench/async_serial_port_tb.sv]
// Self-checking bench of the serial port against a remote peer.
`default_nettype none
`define CHECK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin fail_count++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module async_serial_port_tb
  import serial_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              ref_clk, nrst, cpu_wr, cpu_rd, timer_tick, serial_in_pin, serial_out_pin;
  logic              transmit_done_interrupt, receive_done_interrupt, receive_error_interrupt;
  logic              got_valid, len8, two_stop, rd_q;
  logic [ADDR_W-1:0] cpu_addr;
  logic [7:0]        cpu_wdata, cpu_rdata;
  logic [8:0]        got_word, note;
  logic [1:0]        par_sel;
  logic [31:0]       seed;
  logic [8:0]        exp_q[$];
  int                fail_count, samples_checked, err_seen;
  // Design and remote peer.
  async_serial_port dut_u (.ref_clk(ref_clk), .nrst(nrst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .timer_tick(timer_tick),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .transmit_done_interrupt(transmit_done_interrupt), .receive_done_interrupt(receive_done_interrupt),
    .receive_error_interrupt(receive_error_interrupt));
  remote_serial_peer peer_u (.ref_clk(ref_clk), .line_in(serial_out_pin), .line_out(serial_in_pin),
    .parity(par_sel), .len8(len8), .two_stop(two_stop), .got_valid(got_valid), .got_word(got_word));
  // Clock and an external tick every second cycle.
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) timer_tick <= ~timer_tick;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Compares each read answer or remote frame with the oldest note.
  always @(posedge ref_clk) begin
    if (rd_q || got_valid) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      if (rd_q) `CHECK("cpu_rdata", note, {1'h0, cpu_rdata})
      else `CHECK("remote_frame", note, got_word)
    end
    rd_q <= cpu_rd;
    if (receive_error_interrupt === 1'h1) begin
      err_seen++;
    end
  end
  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0 && exp_q.size() == 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cpu_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'h1;
    @(negedge ref_clk);
    cpu_wr = 1'h0;
  endtask
  task automatic cpu_read(input logic [15:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    cpu_addr = a;
    cpu_rd = 1'h1;
    exp_q.push_back({1'h0, e});
    @(negedge ref_clk);
    cpu_rd = 1'h0;
  endtask
  // Bounded wait for a done pulse; n counts the cycles.
  task automatic wait_pulse(input logic rx, output int n);
    for (n = 0; n < 3000; n++) begin
      @(posedge ref_clk);
      if ((rx ? receive_done_interrupt : transmit_done_interrupt) === 1'h1) return;
    end
    `CHECK("done_wait", 1'h1, 1'h0)
    report_and_stop();
  endtask
  // enables off, settle, format change, enables on, settle
  task automatic set_fmt(input logic [1:0] p, input logic l, input logic s);
    cpu_write(ADDR_MODE, {3'h4, par_sel, len8, two_stop, 1'h1});
    repeat (8) @(negedge ref_clk);
    par_sel = p;
    len8 = l;
    two_stop = s;
    cpu_write(ADDR_MODE, {3'h4, p, l, s, 1'h1});
    cpu_write(ADDR_MODE, {3'h7, p, l, s, 1'h1});
    repeat (8) @(negedge ref_clk);
  endtask
  // one transmitted character and its length in clocks
  task automatic tx_one();
    int n;
    int b;
    seed = lfsr_next(seed);
    b = 32 * (9 + len8 + (par_sel != PAR_NONE) + two_stop);
    exp_q.push_back({1'h1, len8 ? seed[7:0] : {1'h0, seed[6:0]}});
    cpu_write(ADDR_DATA, seed[7:0]);
    wait_pulse(1'h0, n);
    `CHECK("frame_clocks", 1'h1, (n >= b - 2 && n <= b + 8))
  endtask
  task automatic rx_one(input logic flip);
    int n;
    seed = lfsr_next(seed);
    fork
      peer_u.send_frame(seed[7:0], flip);
      wait_pulse(1'h1, n);
    join
    cpu_read(ADDR_DATA, len8 ? seed[7:0] : {1'h0, seed[6:0]});
  endtask
  // Main sequence.
  initial begin
    nrst = 1'h0;
    cpu_addr = '0;
    cpu_wdata = '0;
    cpu_wr = 1'h0;
    cpu_rd = 1'h0;
    timer_tick = 1'h0;
    rd_q = 1'h0;
    seed = 32'hcb7b;
    par_sel = PAR_NONE;
    len8 = 1'h1;
    two_stop = 1'h0;
    fail_count = 0;
    samples_checked = 0;
    err_seen = 0;
    repeat (20) @(negedge ref_clk);
    nrst = 1'h1;
    cpu_read(ADDR_MODE, MODE_RESET);
    cpu_read(ADDR_RATE, RATE_RESET);
    cpu_read(ADDR_ERR, ZERO_BYTE);
    cpu_read(16'hff74, ZERO_BYTE);
    cpu_write(ADDR_DATA, 8'h12);
    cpu_read(ADDR_DATA, RXB_RESET);
    // tick every two cycles, divider eight
    cpu_write(ADDR_RATE, 8'h48);
    cpu_read(ADDR_RATE, 8'h48);
    // every parity, length and stop setting
    for (int f = 0; f < 16; f++) begin
      set_fmt(f[3:2], f[1], f[0]);
      tx_one();
      rx_one(1'h0);
    end
    // external timer tick as base clock, same bit time as before
    cpu_write(ADDR_MODE, {3'h4, par_sel, len8, two_stop, 1'h1});
    cpu_write(ADDR_RATE, 8'h08);
    // bad parity flagged, read clears it
    set_fmt(PAR_ODD, 1'h1, 1'h0);
    peer_u.send_frame(8'h5a, 1'h1);
    cpu_read(ADDR_ERR, 8'h04);
    cpu_read(ADDR_ERR, ZERO_BYTE);
    cpu_read(ADDR_DATA, 8'h5a);
    // zero parity bit is not judged
    set_fmt(PAR_ZERO, 1'h1, 1'h0);
    rx_one(1'h1);
    cpu_read(ADDR_ERR, ZERO_BYTE);
    peer_u.send_frame(8'h3c, 1'h0);
    peer_u.send_frame(8'hc3, 1'h0);
    cpu_read(ADDR_ERR, 8'h01);
    cpu_read(ADDR_DATA, 8'h3c);
    // power off ignores the line and resets the buffer
    cpu_write(ADDR_MODE, {3'h4, par_sel, len8, two_stop, 1'h1});
    cpu_write(ADDR_MODE, MODE_RESET);
    peer_u.send_frame(8'h00, 1'h0);
    cpu_read(ADDR_DATA, RXB_RESET);
    cpu_read(ADDR_ERR, ZERO_BYTE);
    repeat (4) @(negedge ref_clk);
    // Only the bad parity and the overrun frames raise an error pulse.
    `CHECK("error_pulses", 2, err_seen)
    report_and_stop();
  end
endmodule
`default_nettype wire
